// ===== rtl/adf_pkg.sv
// shared constants, types and conversion helpers of the dual audio input/convert core
// assumes a single system clock domain; link pins are sampled, not used as clocks
`default_nettype none

package adf_pkg;

  // ----------------------------------------------------------------
  // pin vector layout and sampling
  // ----------------------------------------------------------------
  localparam int PIN_BITCLK = 0;
  localparam int PIN_WORDCLK = 1;
  localparam int PIN_DL = 2;
  localparam int PIN_DR = 3;
  localparam int PIN_FA = 4;
  localparam int PIN_FB = 5;
  localparam int PIN_FC = 6;
  localparam int PIN_COUNT = 7;

  // ----------------------------------------------------------------
  // code widths and converter split
  // ----------------------------------------------------------------
  localparam int SHIFT_W = 20;
  localparam int CODE_W = 18;
  localparam int WEIGHTED_W = 10;
  localparam int RESIDUE_W = 8;
  localparam int DEF_OFFSET_BIT = 8;
  localparam logic [CODE_W-1:0] SIGN_FLIP = 18'h20000;
  localparam logic [CODE_W-1:0] CODE_RST = 18'h00000;

  // ----------------------------------------------------------------
  // system clock to sample rate ratio, in system clock cycles
  // ----------------------------------------------------------------
  localparam int RATIO_W = 10;
  localparam logic [RATIO_W-1:0] SYS_RATIO_MIN = 10'h030;
  localparam logic [RATIO_W-1:0] SYS_RATIO_MAX = 10'h180;
  localparam logic [RATIO_W-1:0] RATIO_RST = 10'h000;

  // ----------------------------------------------------------------
  // register map (byte offsets) and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_LEFT = 4'h8;
  localparam logic [3:0] REG_RIGHT = 4'hc;
  localparam logic CTRL_SMALL_RST = 1'b0;
  localparam int ST_FMT = 0;
  localparam int ST_INV = 2;
  localparam int ST_OFFL = 3;
  localparam int ST_OFFR = 4;
  localparam int ST_RATE_OK = 5;
  localparam int ST_RATIO = 16;

  typedef enum logic [1:0] {FMT_SER16, FMT_SER18, FMT_PAR20, FMT_PAR18} adf_format_t;

  typedef struct packed {
    logic positive;
    logic [WEIGHTED_W-1:0] word;
    logic [RESIDUE_W-1:0] residue;
  } adf_conv_t;

  function automatic adf_format_t decodeFormat(input logic a, input logic b,
                                               input logic smallPkg);
    if (smallPkg) begin
      return a ? FMT_PAR18 : FMT_SER18;
    end
    case ({a, b})
      2'b00: return FMT_SER16;
      2'b01: return FMT_SER18;
      2'b10: return FMT_PAR20;
      default: return FMT_PAR18;
    endcase
  endfunction : decodeFormat

  // msb-first shift register to an 18-bit two's complement code
  function automatic logic [CODE_W-1:0] normalize(input logic [SHIFT_W-1:0] sr,
                                                  input adf_format_t f);
    case (f)
      FMT_SER16: return {sr[15:0], 2'b00};
      FMT_PAR20: return sr[19:2];
      default: return sr[17:0];
    endcase
  endfunction : normalize

  function automatic adf_conv_t convertCode(input logic [CODE_W-1:0] code,
                                            input logic [CODE_W-1:0] weight);
    adf_conv_t r;
    logic [CODE_W-1:0] adj;
    r.positive = !code[CODE_W-1] && (code != CODE_RST);
    adj = r.positive ? code - weight : code;
    adj = adj ^ SIGN_FLIP;
    r.word = adj[CODE_W-1:RESIDUE_W];
    r.residue = adj[RESIDUE_W-1:0];
    return r;
  endfunction : convertCode

endpackage : adf_pkg

`default_nettype wire

// ===== rtl/adf_shape_if.sv
// residue and one-bit output between the core and a noise shaper
// assumes both ends sit on the same system clock
`default_nettype none

interface adf_shape_if #(parameter int RES_W = 8);
  logic [RES_W-1:0] residue;
  logic bitOut;
  modport source (output residue, input bitOut);
  modport shaper (input residue, output bitOut);
endinterface : adf_shape_if

`default_nettype wire

// ===== rtl/adf_noise_shaper.sv
// first-order noise shaper feeding a one-bit converter
// assumes residue is held between sample transfers
`default_nettype none

module adf_noise_shaper
  import adf_pkg::*;
#(
  parameter int RES_W = RESIDUE_W
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // residue in, bit out
  adf_shape_if.shaper sh
);

  logic [RES_W-1:0] acc;
  logic [RES_W:0] sum;

  assign sum = {1'b0, acc} + {1'b0, sh.residue};

  // runs on every rising system clock edge; carry is the one-bit stream
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      acc <= '0;
      sh.bitOut <= 1'b0;
    end else begin
      acc <= sum[RES_W-1:0];
      sh.bitOut <= sum[RES_W];
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  a_zero_quiet: assert property (
    (sh.residue == '0) |=> !sh.bitOut)
    else $error("shaper emitted a one for zero residue");

  a_shaper_runs: assert property (
    (sh.residue != '0) |-> ##[1:256] (sh.bitOut || !$stable(sh.residue)))
    else $error("shaper silent for nonzero residue");

endmodule : adf_noise_shaper

`default_nettype wire

// ===== rtl/adf_input_format.sv
// input format selection and digital conversion core of a dual audio converter
// assumes link pins are asynchronous and slow against ref_clk (at least 4 samples per level)
// Contract
// - mode pins pick one of four input formats
// - serial: second pin selects 16 or 18 bits
// - small package: one pin, 18-bit serial/parallel
// - positive codes lose offset weight, offset on
// - ten-bit weighted part, residue noise shaped
// - shaper and one-bit run on system clock
// - shift on bit clock rise, transfer on fall; the code transfers on the rise when wordInv is set (large-package parallel, third pin low)
//
// Local design decisions: the Avalon-MM interface to the registers and the register offsets.
`default_nettype none

module adf_input_format
  import adf_pkg::*;
#(
  parameter int OFFSET_BIT = DEF_OFFSET_BIT
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // audio link pins
  input wire logic serial_bit_clock,
  input wire logic word_latch_clock,
  input wire logic dataLeft,
  input wire logic dataRight,
  // static format pins
  input wire logic format_select_a,
  input wire logic format_select_b,
  input wire logic format_select_c,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // converter drive
  output logic [WEIGHTED_W-1:0] dacWordLeft,
  output logic [WEIGHTED_W-1:0] dacWordRight,
  output logic offsetLeft,
  output logic offsetRight,
  output logic bitLeft,
  output logic bitRight
);

  localparam logic [CODE_W-1:0] OFFSET_WEIGHT = CODE_W'(1) << OFFSET_BIT;

  // ----------------------------------------------------------------
  // pin sampling
  // ----------------------------------------------------------------
  logic [PIN_COUNT-1:0] pinsRaw;
  logic [PIN_COUNT-1:0] syncA;
  logic [PIN_COUNT-1:0] syncB;
  logic [PIN_COUNT-1:0] syncC;
  logic [PIN_COUNT-1:0] pinLvl;
  logic [PIN_COUNT-1:0] next_pinLvl;
  logic [PIN_COUNT-1:0] rise;
  logic [PIN_COUNT-1:0] fall;

  assign pinsRaw = {format_select_c, format_select_b, format_select_a, dataRight, dataLeft,
                    word_latch_clock, serial_bit_clock};

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      syncA <= '0;
      syncB <= '0;
      syncC <= '0;
    end else begin
      syncA <= pinsRaw;
      syncB <= syncA;
      syncC <= syncB;
    end
  end

  // a level counts only once the last two stages agree
  genvar p;
  generate
    for (p = 0; p < PIN_COUNT; p++) begin : g_pin
      assign next_pinLvl[p] = (syncB[p] == syncC[p]) ? syncC[p] : pinLvl[p];
    end
  endgenerate

  assign rise = next_pinLvl & ~pinLvl;
  assign fall = ~next_pinLvl & pinLvl;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pinLvl <= '0;
    end else begin
      pinLvl <= next_pinLvl;
    end
  end

  // ----------------------------------------------------------------
  // format decode
  // ----------------------------------------------------------------
  logic ctrlSmall;
  adf_format_t fmt;
  logic wordInv;
  logic serialMode;

  // pins are static, so re-decoding every cycle costs nothing and tracks strap changes
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      fmt <= FMT_SER16;
      wordInv <= 1'b0;
    end else begin
      fmt <= decodeFormat(pinLvl[PIN_FA], pinLvl[PIN_FB], ctrlSmall);
      wordInv <= !ctrlSmall && pinLvl[PIN_FA] && !pinLvl[PIN_FC];
    end
  end

  assign serialMode = (fmt == FMT_SER16) || (fmt == FMT_SER18);

  // ----------------------------------------------------------------
  // shifting and word framing
  // ----------------------------------------------------------------
  logic [SHIFT_W-1:0] shiftL;
  logic [SHIFT_W-1:0] shiftR;
  logic [CODE_W-1:0] holdLeft;
  logic wordUp;
  logic xfer;
  logic [CODE_W-1:0] newCodeL;
  logic [CODE_W-1:0] newCodeR;

  assign wordUp = wordInv ? fall[PIN_WORDCLK] : rise[PIN_WORDCLK];
  assign xfer = wordInv ? rise[PIN_WORDCLK] : fall[PIN_WORDCLK];

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      shiftL <= '0;
      shiftR <= '0;
    end else if (rise[PIN_BITCLK]) begin
      shiftL <= {shiftL[SHIFT_W-2:0], pinLvl[PIN_DL]};
      if (!serialMode) begin
        shiftR <= {shiftR[SHIFT_W-2:0], pinLvl[PIN_DR]};
      end
    end
  end

  // serial stream on the left pin carries left then right
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      holdLeft <= CODE_RST;
    end else if (serialMode && wordUp) begin
      holdLeft <= normalize(shiftL, fmt);
    end
  end

  assign newCodeL = serialMode ? holdLeft : normalize(shiftL, fmt);
  assign newCodeR = serialMode ? normalize(shiftL, fmt) : normalize(shiftR, fmt);

  // ----------------------------------------------------------------
  // conversion split and offset
  // ----------------------------------------------------------------
  adf_conv_t convL;
  adf_conv_t convR;
  logic [CODE_W-1:0] codeL;
  logic [CODE_W-1:0] codeR;
  logic [RESIDUE_W-1:0] residueL;
  logic [RESIDUE_W-1:0] residueR;

  assign convL = convertCode(newCodeL, OFFSET_WEIGHT);
  assign convR = convertCode(newCodeR, OFFSET_WEIGHT);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      codeL <= CODE_RST;
      codeR <= CODE_RST;
      dacWordLeft <= '0;
      dacWordRight <= '0;
      residueL <= '0;
      residueR <= '0;
      offsetLeft <= 1'b0;
      offsetRight <= 1'b0;
    end else if (xfer) begin
      codeL <= newCodeL;
      codeR <= newCodeR;
      dacWordLeft <= convL.word;
      dacWordRight <= convR.word;
      residueL <= convL.residue;
      residueR <= convR.residue;
      offsetLeft <= convL.positive;
      offsetRight <= convR.positive;
    end
  end

  adf_shape_if #(.RES_W(RESIDUE_W)) shIf [2] ();
  assign shIf[0].residue = residueL;
  assign shIf[1].residue = residueR;
  assign bitLeft = shIf[0].bitOut;
  assign bitRight = shIf[1].bitOut;

  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_ch
      adf_noise_shaper #(.RES_W(RESIDUE_W)) u_shaper (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .sh(shIf[c].shaper)
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // system clock per sample, measured between transfers
  // ----------------------------------------------------------------
  logic [RATIO_W-1:0] ratioCnt;
  logic [RATIO_W-1:0] ratioLast;
  logic rateOk;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ratioCnt <= RATIO_RST;
      ratioLast <= RATIO_RST;
    end else if (xfer) begin
      ratioCnt <= RATIO_RST;
      ratioLast <= (&ratioCnt) ? ratioCnt : RATIO_W'(ratioCnt + 1'b1);
    end else if (!(&ratioCnt)) begin
      ratioCnt <= RATIO_W'(ratioCnt + 1'b1);
    end
  end

  // only a flag: the shaper runs regardless, quality drops outside the band
  assign rateOk = (ratioLast >= SYS_RATIO_MIN) && (ratioLast <= SYS_RATIO_MAX);

  // ----------------------------------------------------------------
  // avalon-mm registers
  // ----------------------------------------------------------------
  logic [31:0] readMux;

  always_comb begin
    readMux = 32'h00000000;
    case (avs_address)
      REG_CTRL: readMux[0] = ctrlSmall;
      REG_STATUS: begin
        readMux[ST_FMT+1:ST_FMT] = fmt;
        readMux[ST_INV] = wordInv;
        readMux[ST_OFFL] = offsetLeft;
        readMux[ST_OFFR] = offsetRight;
        readMux[ST_RATE_OK] = rateOk;
        readMux[ST_RATIO+RATIO_W-1:ST_RATIO] = ratioLast;
      end
      REG_LEFT: readMux[CODE_W-1:0] = codeL;
      REG_RIGHT: readMux[CODE_W-1:0] = codeR;
      default: readMux = 32'h00000000;
    endcase
  end

  // one wait cycle per access, then a single low cycle of waitrequest
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
      avs_readdata <= avs_read ? readMux : 32'h00000000;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctrlSmall <= CTRL_SMALL_RST;
    end else if (avs_write && !avs_waitrequest && avs_address == REG_CTRL) begin
      ctrlSmall <= avs_writedata[0];
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence s_word_fall;
    (pinLvl[PIN_WORDCLK] && !wordInv && !ctrlSmall) ##1 (!pinLvl[PIN_WORDCLK] && !wordInv);
  endsequence

  a_fmt_ser16: assert property (
    (!ctrlSmall && !pinLvl[PIN_FA] && !pinLvl[PIN_FB]) |=> (fmt == FMT_SER16))
    else $error("16-bit serial not selected");

  a_fmt_ser18: assert property (
    (!ctrlSmall && !pinLvl[PIN_FA] && pinLvl[PIN_FB]) |=> (fmt == FMT_SER18) && !wordInv)
    else $error("18-bit serial not selected");

  a_fmt_par_inv: assert property (
    (!ctrlSmall && pinLvl[PIN_FA] && !pinLvl[PIN_FB])
    |=> (fmt == FMT_PAR20) && (wordInv == !$past(pinLvl[PIN_FC])))
    else $error("20-bit parallel or word clock polarity wrong");

  a_fmt_small: assert property (
    ctrlSmall |=> (fmt == ($past(pinLvl[PIN_FA]) ? FMT_PAR18 : FMT_SER18)) && !wordInv)
    else $error("small package format wrong");

  a_offset_sub: assert property (
    (xfer && !newCodeL[CODE_W-1] && newCodeL != CODE_RST)
    |=> offsetLeft && ({dacWordLeft, residueL} == (($past(newCodeL) - OFFSET_WEIGHT) ^ SIGN_FLIP)))
    else $error("positive code offset not applied");

  a_split_neg: assert property (
    (xfer && newCodeR[CODE_W-1])
    |=> !offsetRight && ({dacWordRight, residueR} == ($past(newCodeR) ^ SIGN_FLIP)))
    else $error("negative code split wrong");

  a_xfer_fall: assert property (
    s_word_fall |-> (codeL == $past(newCodeL)) && (codeR == $past(newCodeR)))
    else $error("word not transferred on word clock fall");

  a_bit_shift: assert property (
    rise[PIN_BITCLK] |=> (shiftL[0] == $past(pinLvl[PIN_DL]))
    ##1 ($stable(shiftL) || rise[PIN_BITCLK]))
    else $error("bit not shifted on bit clock rise");

endmodule : adf_input_format

`default_nettype wire

// ===== sim/adf_host_model.sv
// upstream host model: drives the audio link pins one frame at a time
// assumes ref_clk at 10 MHz; the bit clock runs only inside frames
`default_nettype none

module adf_host_model (
  // pacing clock
  input wire logic ref_clk,
  // link pins
  output logic serial_bit_clock,
  output logic word_latch_clock,
  output logic dataLeft,
  output logic dataRight
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    serial_bit_clock = 1'b0;
    word_latch_clock = 1'b0;
    dataLeft = 1'b0;
    dataRight = 1'b1;
  end

  // one bit per 800 ns; data only moves while the bit clock is low
  task automatic shiftBit(input logic l, input logic r);
    @(posedge ref_clk);
    dataLeft <= l;
    dataRight <= r;
    repeat (3) @(posedge ref_clk);
    serial_bit_clock <= 1'b1;
    repeat (4) @(posedge ref_clk);
    serial_bit_clock <= 1'b0;
  endtask : shiftBit

  task automatic toggleWord();
    @(posedge ref_clk);
    word_latch_clock <= ~word_latch_clock;
    repeat (8) @(posedge ref_clk);
  endtask : toggleWord

  // the last word clock edge of a frame is always the transfer edge
  task automatic sendFrame(input logic [19:0] l, input logic [19:0] r, input int n,
                           input logic par, input logic idle);
    int i;
    if (word_latch_clock !== idle) toggleWord();
    for (i = n - 1; i >= 0; i--) shiftBit(l[i], par ? r[i] : ~l[i]);
    toggleWord();
    if (!par) for (i = n - 1; i >= 0; i--) shiftBit(r[i], ~r[i]);
    toggleWord();
    // released lines flip so a stale level is never mistaken for data
    @(posedge ref_clk);
    dataLeft <= ~dataLeft;
    dataRight <= ~dataRight;
  endtask : sendFrame
endmodule : adf_host_model

`default_nettype wire

// ===== sim/adf_input_format_tb.sv
// self-checking bench of the input format and conversion core
// assumes the host model on the link pins and an avalon master task here
`default_nettype none

module adf_input_format_tb import adf_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int OFFB = 8;
  logic ref_clk, resetn, fmtA, fmtB, fmtC, avRd, avWr, waitReq;
  logic bitClk, wordClk, datL, datR, offL, offR, bitL, bitR;
  logic [3:0] avAddr;
  logic [31:0] avWdata, avRdata, rd;
  logic [9:0] wordL, wordR;
  // first and third low decode as if third were high
  logic [2:0] fmtTab [8] = '{3'b001, 3'b011, 3'b101, 3'b100, 3'b111, 3'b110, 3'b000, 3'b010};
  logic [2:0] expTab [8] = '{3'h0, 3'h1, 3'h2, 3'h6, 3'h3, 3'h7, 3'h0, 3'h1};
  int err_count, comparisons, cycles;

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  adf_host_model host (.ref_clk(ref_clk), .serial_bit_clock(bitClk),
    .word_latch_clock(wordClk), .dataLeft(datL), .dataRight(datR));

  adf_input_format #(.OFFSET_BIT(OFFB)) dut (.ref_clk(ref_clk), .resetn(resetn),
    .serial_bit_clock(bitClk), .word_latch_clock(wordClk), .dataLeft(datL),
    .dataRight(datR), .format_select_a(fmtA), .format_select_b(fmtB),
    .format_select_c(fmtC), .avs_address(avAddr), .avs_read(avRd), .avs_write(avWr),
    .avs_writedata(avWdata), .avs_readdata(avRdata), .avs_waitrequest(waitReq),
    .dacWordLeft(wordL), .dacWordRight(wordR), .offsetLeft(offL), .offsetRight(offR),
    .bitLeft(bitL), .bitRight(bitR));

  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask : chk

  // request held until waitrequest is seen low at a rising edge
  task automatic xfer(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge ref_clk);
    avAddr <= a;
    avWdata <= wd;
    avWr <= wr;
    avRd <= ~wr;
    do begin
      @(posedge ref_clk);
      n++;
    end while (waitReq !== 1'b0);
    rd = avRdata;
    // one wait state: taken at the first edge, answered at the second
    chk("bus wait cycles", 32'h2, n);
    avWr <= 1'b0;
    avRd <= 1'b0;
  endtask : xfer

  task automatic setPins(input logic [2:0] p);
    @(posedge ref_clk);
    fmtA <= p[2];
    fmtB <= p[1];
    fmtC <= p[0];
    repeat (8) @(posedge ref_clk);
  endtask : setPins

  function automatic logic [17:0] expCode(input logic [19:0] v, input int n);
    return (n == 16) ? {v[15:0], 2'b00} : (n == 20) ? v[19:2] : v[17:0];
  endfunction : expCode

  function automatic logic isPos(input logic [17:0] c);
    return !c[17] && c != 18'h00000;
  endfunction : isPos

  function automatic logic [17:0] expAdj(input logic [17:0] c);
    return (isPos(c) ? c - (18'h00001 << OFFB) : c) ^ 18'h20000;
  endfunction : expAdj

  task automatic frameCheck(input logic [19:0] l, input logic [19:0] r, input int n,
                            input logic par, input logic idle);
    logic [17:0] cl, cr;
    logic [17:0] adjL, adjR;
    int onesL, onesR, i;
    cl = expCode(l, n);
    cr = expCode(r, n);
    adjL = expAdj(cl);
    adjR = expAdj(cr);
    onesL = 0;
    onesR = 0;
    host.sendFrame(l, r, n, par, idle);
    repeat (10) @(posedge ref_clk);
    xfer(1'b0, REG_LEFT, 32'h0);
    chk("left code", {14'h0, cl}, rd);
    xfer(1'b0, REG_RIGHT, 32'h0);
    chk("right code", {14'h0, cr}, rd);
    chk("left word", {22'h0, adjL[17:8]}, {22'h0, wordL});
    chk("right word", {22'h0, adjR[17:8]}, {22'h0, wordR});
    chk("offsets", {30'h0, isPos(cr), isPos(cl)}, {30'h0, offR, offL});
    xfer(1'b0, REG_STATUS, 32'h0);
    chk("status offsets", {30'h0, isPos(cr), isPos(cl)}, {30'h0, rd[4:3]});
    // 256 cycles of an 8-bit first-order shaper carry exactly the residue
    for (i = 0; i < 256; i++) begin
      @(posedge ref_clk);
      onesL += (bitL === 1'b1);
      onesR += (bitR === 1'b1);
    end
    chk("left ones", {24'h0, adjL[7:0]}, onesL);
    chk("right ones", {24'h0, adjR[7:0]}, onesR);
  endtask : frameCheck

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic testReset();
    repeat (8) @(posedge ref_clk);
    chk("idle words", 32'h0, {12'h0, wordL, wordR});
    xfer(1'b1, REG_STATUS, 32'hffffffff);
    xfer(1'b0, REG_STATUS, 32'h0);
    chk("status", 32'h0, rd);
    xfer(1'b1, REG_CTRL, 32'hffffffff);
    xfer(1'b0, REG_CTRL, 32'h0);
    chk("ctrl", 32'h1, rd);
    xfer(1'b1, REG_CTRL, 32'h0);
  endtask : testReset

  task automatic testFormats();
    int k;
    for (k = 0; k < 8; k++) begin
      setPins(fmtTab[k]);
      xfer(1'b0, REG_STATUS, 32'h0);
      chk("format", {29'h0, expTab[k]}, {29'h0, rd[2:0]});
    end
  endtask : testFormats

  task automatic testSerial();
    setPins(3'b011);
    frameCheck(20'h1ffff, 20'h20000, 18, 1'b0, 1'b0);
    frameCheck(20'h00000, 20'h00001, 18, 1'b0, 1'b0);
    setPins(3'b001);
    frameCheck(20'h08000, 20'h01234, 16, 1'b0, 1'b0);
  endtask : testSerial

  task automatic testParallel();
    setPins(3'b101);
    frameCheck(20'h12345, 20'hfedcb, 20, 1'b1, 1'b0);
    setPins(3'b110);
    frameCheck(20'h2abcd, 20'h05555, 18, 1'b1, 1'b1);
  endtask : testParallel

  // strap combinations that would decode otherwise in the larger package
  task automatic testSmall();
    xfer(1'b1, REG_CTRL, 32'h1);
    setPins(3'b000);
    xfer(1'b0, REG_STATUS, 32'h0);
    chk("small serial", 32'h1, {29'h0, rd[2:0]});
    frameCheck(20'h1fff0, 20'h3ff00, 18, 1'b0, 1'b0);
    setPins(3'b100);
    xfer(1'b0, REG_STATUS, 32'h0);
    chk("small parallel", 32'h3, {29'h0, rd[2:0]});
    frameCheck(20'h00100, 20'h3ffff, 18, 1'b1, 1'b0);
    xfer(1'b1, REG_CTRL, 32'h0);
  endtask : testSmall

  // ----------------------------------------------------------------
  // sequence and watchdog
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 30000) begin
      $display("MISMATCH run length expected below 30000 seen 30000");
      err_count++;
      complete_run();
    end
  end

  initial begin
    resetn = 1'b0;
    {fmtA, fmtB, fmtC, avRd, avWr} = 5'h04;
    avAddr = 4'h0;
    avWdata = 32'h0;
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
    testReset();
    testFormats();
    testSerial();
    testParallel();
    testSmall();
    complete_run();
  end
endmodule : adf_input_format_tb

`default_nettype wire
